// ---- rtl/vcl_clutch.sv ----
// Virtual clutch controller: address mode 2 and one-shot mode, with an
// Avalon-MM register slave that holds command, mode and the two settings.
// Assumes a 200 MHz ref_clk, synchronous active-low reset and an axis value
// that is synchronous to ref_clk.
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`include "vcl_consts.svh"

module vcl_clutch
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic signed [31:0] axis_pos,
   input wire logic major_err,
   input wire logic servo_off_req,
   output logic clutch_on,
   output logic servo_off_grant
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   localparam int TICK_CYC = `VCL_TICK_CYC;
   localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

   vcl_pkg::vcl_cfg_t cfg;
   vcl_pkg::vcl_seq_t seq;
   vcl_pkg::vcl_seq_t next_seq;
   logic [7:0] tick_cnt;
   logic tick;
   logic mode_err;
   logic err_hold;
   logic next_err_hold;
   logic next_on;
   logic cmd_prev;
   logic primed;
   logic signed [31:0] axis_prev;
   logic signed [31:0] acc;
   logic signed [31:0] next_acc;
   logic signed [31:0] pre_t;
   logic signed [31:0] next_pre;
   logic signed [31:0] post_t;
   logic signed [31:0] next_post;
   logic signed [31:0] delta;
   logic rise;
   logic bus_take;

   // ----------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------
   // True when the axis moved through addr between two samples, either way
   function automatic logic crossed(input logic signed [31:0] prev,
                                    input logic signed [31:0] cur,
                                    input logic signed [31:0] addr);
      crossed = ((prev < addr) && (cur >= addr)) || ((prev > addr) && (cur <= addr));
   endfunction : crossed

   // True when a signed travel has met its signed target
   function automatic logic reached(input logic signed [31:0] trav,
                                    input logic signed [31:0] tgt);
      reached = (tgt >= 0) ? (trav >= tgt) : (trav <= tgt);
   endfunction : reached

   // True when the axis met addr at or after first in its direction of travel
   function automatic logic passes(input logic signed [31:0] prev,
                                   input logic signed [31:0] cur,
                                   input logic signed [31:0] first,
                                   input logic signed [31:0] addr);
      passes = crossed(prev, cur, addr) && ((cur >= prev) ? (addr >= first) : (addr <= first));
   endfunction : passes

   // ----------------------------------------------------------------------
   // Operation-cycle tick
   // ----------------------------------------------------------------------
   // Divider gives a one-cycle enable; all clutch state moves on it
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         tick_cnt <= 8'h00;
         tick <= 1'b0;
      end
      else
      begin
         tick_cnt <= (tick_cnt == TICK_LAST) ? 8'h00 : tick_cnt + 8'h01;
         tick <= (tick_cnt == TICK_LAST);
      end
   end

   // ----------------------------------------------------------------------
   // Avalon-MM slave
   // ----------------------------------------------------------------------
   // One wait state per access; writes land when waitrequest is low
   assign bus_take = (read || write) && !waitrequest;

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         waitrequest <= 1'b1;
      else
         waitrequest <= !((read || write) && waitrequest);
   end

   // Read data is captured during the wait cycle so it stands on release
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         readdata <= 32'h00000000;
      else if (read && waitrequest)
      begin
         if (address == `VCL_REG_CTRL)
            readdata <= {30'h00000000, cfg.err_rel_en, cfg.cmd};
         else if (address == `VCL_REG_MODE)
            readdata <= {29'h00000000, cfg.mode};
         else if (address == `VCL_REG_ON_ADDR)
            readdata <= cfg.on_addr;
         else if (address == `VCL_REG_OFF_ADDR)
            readdata <= cfg.off_addr;
         else if (address == `VCL_REG_STATUS)
            readdata <= {27'h0000000, servo_off_grant, (seq != vcl_pkg::SEQ_IDLE),
                         err_hold, mode_err, clutch_on};
         else
            readdata <= 32'h00000000; // Unmapped reads as zero
      end
   end

   // Control word: command bit and error-time release option
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         cfg.cmd <= 1'b0;
         cfg.err_rel_en <= 1'b0;
      end
      else if (bus_take && write && (address == `VCL_REG_CTRL))
      begin
         cfg.cmd <= writedata[`VCL_CTRL_CMD_BIT];
         cfg.err_rel_en <= writedata[`VCL_CTRL_ERR_REL_BIT];
      end
   end

   // Mode selector; a bad value is flagged and the old mode stays in force
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         cfg.mode <= `VCL_MODE_RESET;
         mode_err <= 1'b0;
      end
      else if (bus_take && write && (address == `VCL_REG_MODE))
      begin
         mode_err <= (writedata > 32'(`VCL_MODE_MAX));
         if (writedata <= 32'(`VCL_MODE_MAX))
            cfg.mode <= writedata[2:0];
      end
   end

   // Settings are whole 32-bit words, so no half-written value is seen
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         cfg.on_addr <= `VCL_ADDR_RESET;
         cfg.off_addr <= `VCL_ADDR_RESET;
      end
      else if (bus_take && write && (address == `VCL_REG_ON_ADDR))
         cfg.on_addr <= writedata;
      else if (bus_take && write && (address == `VCL_REG_OFF_ADDR))
         cfg.off_addr <= writedata;
   end

   // ----------------------------------------------------------------------
   // Clutch decision for one operation cycle
   // ----------------------------------------------------------------------
   // Movement since last tick wraps like the axis counter does
   assign delta = primed ? (axis_pos - axis_prev) : 32'sh00000000;
   assign rise = cfg.cmd && !cmd_prev;

   // Both points met in one cycle are taken in the order the axis meets them,
   // so only a pass that would return the state leaves the status bit alone
   always_comb
   begin
      next_on = clutch_on;
      next_seq = seq;
      next_acc = acc;
      next_pre = pre_t;
      next_post = post_t;
      next_err_hold = err_hold;
      if (err_hold)
      begin
         next_on = 1'b0;
         next_seq = vcl_pkg::SEQ_IDLE;
         if (!cfg.cmd && !major_err)
            next_err_hold = 1'b0;
      end
      else if (cfg.err_rel_en && major_err)
      begin
         next_on = 1'b0;
         next_seq = vcl_pkg::SEQ_IDLE;
         next_err_hold = 1'b1;
      end
      else if (cfg.mode == `VCL_MODE_ADDR2)
      begin
         next_seq = vcl_pkg::SEQ_IDLE;
         if (!cfg.cmd)
            next_on = 1'b0;
         else if (primed && !clutch_on)
         begin
            if (crossed(axis_prev, axis_pos, cfg.on_addr))
               next_on = 1'b1;
            if (next_on && passes(axis_prev, axis_pos, cfg.on_addr, cfg.off_addr))
               next_on = 1'b0;
         end
         else if (primed)
         begin
            if (crossed(axis_prev, axis_pos, cfg.off_addr))
               next_on = 1'b0;
            if (!next_on && passes(axis_prev, axis_pos, cfg.off_addr, cfg.on_addr))
               next_on = 1'b1;
         end
      end
      else if ((cfg.mode == `VCL_MODE_SHOT_ON) || (cfg.mode == `VCL_MODE_SHOT_OFF))
      begin
         // a running sequence ignores the command and a switch between modes 3 and 4
         if (seq == vcl_pkg::SEQ_IDLE)
         begin
            next_on = 1'b0;
            if ((cfg.mode == `VCL_MODE_SHOT_ON) && rise)
            begin
               next_seq = vcl_pkg::SEQ_PRE;
               next_acc = 32'sh00000000;
               next_pre = cfg.off_addr;
               next_post = cfg.on_addr;
            end
         end
         else
            next_acc = acc + delta;
         if ((next_seq == vcl_pkg::SEQ_PRE) && reached(next_acc, next_pre))
         begin
            next_seq = vcl_pkg::SEQ_POST;
            next_acc = next_acc - next_pre;
            next_on = 1'b1;
         end
         if ((next_seq == vcl_pkg::SEQ_POST) && reached(next_acc, next_post))
         begin
            next_seq = vcl_pkg::SEQ_IDLE;
            next_on = 1'b0;
         end
      end
      else
      begin
         next_on = 1'b0;
         next_seq = vcl_pkg::SEQ_IDLE;
      end
   end

   // ----------------------------------------------------------------------
   // Operation-cycle state
   // ----------------------------------------------------------------------
   // State and edge history move only on the tick; first tick only primes
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         clutch_on <= 1'b0;
         seq <= vcl_pkg::SEQ_IDLE;
         acc <= 32'sh00000000;
         pre_t <= 32'sh00000000;
         post_t <= 32'sh00000000;
         err_hold <= 1'b0;
         cmd_prev <= 1'b0;
         axis_prev <= 32'sh00000000;
         primed <= 1'b0;
      end
      else if (tick)
      begin
         clutch_on <= next_on;
         seq <= next_seq;
         acc <= next_acc;
         pre_t <= next_pre;
         post_t <= next_post;
         err_hold <= next_err_hold;
         cmd_prev <= cfg.cmd;
         axis_prev <= axis_pos;
         primed <= 1'b1;
      end
   end

   // Servo-off is honoured only once the command is low and clutch is off
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         servo_off_grant <= 1'b0;
      else
         servo_off_grant <= servo_off_req && !cfg.cmd && !clutch_on;
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   chk_mode_range: assert property (@(posedge ref_clk) disable iff (!rstn)
      cfg.mode <= `VCL_MODE_MAX)
      else $error("mode outside zero to four");

   chk_bad_mode_kept: assert property (@(posedge ref_clk) disable iff (!rstn)
      (bus_take && write && (address == `VCL_REG_MODE) && (writedata > 32'h4))
      |=> ($stable(cfg.mode) && mode_err))
      else $error("bad mode value was accepted");

   chk_status_tick: assert property (@(posedge ref_clk) disable iff (!rstn)
      !$stable(clutch_on) |-> $past(tick))
      else $error("clutch status moved off the tick");

   chk_error_release: assert property (@(posedge ref_clk) disable iff (!rstn)
      (tick && cfg.err_rel_en && major_err) |=> (!clutch_on && err_hold))
      else $error("major error did not release clutch");

   chk_mode4_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
      (tick && !err_hold && (cfg.mode == `VCL_MODE_SHOT_OFF) && (seq == vcl_pkg::SEQ_IDLE))
      |=> (!clutch_on && (seq == vcl_pkg::SEQ_IDLE)))
      else $error("mode four engaged or started");

   chk_zero_pre: assert property (@(posedge ref_clk) disable iff (!rstn)
      (tick && !err_hold && !(cfg.err_rel_en && major_err) && rise
       && (cfg.mode == `VCL_MODE_SHOT_ON) && (seq == vcl_pkg::SEQ_IDLE)
       && (cfg.off_addr == 0) && (cfg.on_addr != 0))
      |=> (clutch_on && (seq == vcl_pkg::SEQ_POST)))
      else $error("zero pre-travel did not engage at once");

   chk_servo_grant: assert property (@(posedge ref_clk) disable iff (!rstn)
      servo_off_grant |-> ($past(!cfg.cmd) && $past(!clutch_on)))
      else $error("servo-off granted while command or clutch on");

   chk_mode2_cmd_low: assert property (@(posedge ref_clk) disable iff (!rstn)
      (tick && (cfg.mode == `VCL_MODE_ADDR2) && !cfg.cmd) |=> !clutch_on)
      else $error("mode two engaged with command low");

   chk_bus_wait: assert property (@(posedge ref_clk) disable iff (!rstn)
      ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not one wait state");

endmodule : vcl_clutch

// ---- rtl/vcl_consts.svh ----
// Constants for the virtual clutch one-shot controller: register offsets,
// field positions, reset values, mode codes and operation-cycle timing.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef VCL_CONSTS_SVH
`define VCL_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define VCL_REG_CTRL 5'h00
`define VCL_REG_MODE 5'h04
`define VCL_REG_ON_ADDR 5'h08
`define VCL_REG_OFF_ADDR 5'h0C
`define VCL_REG_STATUS 5'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define VCL_CTRL_CMD_BIT 0
`define VCL_CTRL_ERR_REL_BIT 1
`define VCL_STAT_CLUTCH_BIT 0
`define VCL_STAT_MODE_ERR_BIT 1
`define VCL_STAT_ERR_HOLD_BIT 2
`define VCL_STAT_SEQ_BIT 3
`define VCL_STAT_SERVO_OK_BIT 4

// ----------------------------------------------------------------------
// Reset values and mode codes
// ----------------------------------------------------------------------
`define VCL_MODE_RESET 3'h0
`define VCL_MODE_ADDR2 3'h2
`define VCL_MODE_SHOT_ON 3'h3
`define VCL_MODE_SHOT_OFF 3'h4
`define VCL_MODE_MAX 3'h4
`define VCL_ADDR_RESET 32'h00000000

// ----------------------------------------------------------------------
// Operation cycle timing
// ----------------------------------------------------------------------
`define VCL_CLK_MHZ 200
`define VCL_OP_CYCLE_NS 1000
`define VCL_TICK_CYC ((`VCL_OP_CYCLE_NS * `VCL_CLK_MHZ) / 1000)

`endif

// ---- rtl/vcl_pkg.sv ----
// Types used by the virtual clutch controller.
// Assumes vcl_consts.svh carries every numeric figure.
package vcl_pkg;

   // ----------------------------------------------------------------------
   // Settings as seen by the control logic
   // ----------------------------------------------------------------------
   typedef struct packed
   {
      logic cmd;
      logic err_rel_en;
      logic [2:0] mode;
      logic signed [31:0] on_addr;
      logic signed [31:0] off_addr;
   } vcl_cfg_t;

   // One-shot sequence phase
   typedef enum logic [1:0]
   {
      SEQ_IDLE,
      SEQ_PRE,
      SEQ_POST
   } vcl_seq_t;

endpackage : vcl_pkg

// ---- sim/vcl_ctl_model.sv ----
// Controller model: Avalon-MM master that sets command, mode and travel words.
// Assumes a slave that holds waitrequest high when idle and drops it per access.
module vcl_ctl_model
(
   input wire logic ref_clk,
   input wire logic waitrequest,
   input wire logic [31:0] readdata,
   output logic [4:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------------
   // Bus idle state
   // ----------------------------------------------------------------------
   // Address parked on an unmapped slot so an idle bus selects nothing
   initial
   begin
      address = 5'h1F;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h00000000;
   end

   // ----------------------------------------------------------------------
   // Transfers
   // ----------------------------------------------------------------------
   // Whole 32-bit word per write, so a travel setting never lands half done
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      address <= a;
      writedata <= d;
      write <= 1'b1;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
      writedata <= ~d; // Stale data must not look valid
   endtask : wr

   // Read data taken at the same edge that shows waitrequest low
   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      address <= a;
      read <= 1'b1;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      d = readdata;
      read <= 1'b0;
   endtask : rd

endmodule : vcl_ctl_model

// ---- sim/test_virtual_clutch_oneshot_control.sv ----
// Self-checking bench for the clutch controller: one task per scenario.
// Assumes one tick every 200 clocks and clutch_on updated one clock later.
`include "vcl_consts.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end

module test_virtual_clutch_oneshot_control;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic signed [31:0] axis_pos = 32'h00000000;
   logic major_err = 1'b0;
   logic servo_off_req = 1'b0;
   logic [4:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic waitrequest;
   logic clutch_on;
   logic servo_off_grant;
   logic err_en = 1'b0;
   logic [31:0] rv;
   int num_errors = 0;
   int cmp_count = 0;

   // 200 MHz clock
   always #2.5 ref_clk = ~ref_clk;

   vcl_clutch i_dut
   (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .address(address),
      .read(read),
      .write(write),
      .writedata(writedata),
      .readdata(readdata),
      .waitrequest(waitrequest),
      .axis_pos(axis_pos),
      .major_err(major_err),
      .servo_off_req(servo_off_req),
      .clutch_on(clutch_on),
      .servo_off_grant(servo_off_grant)
   );

   vcl_ctl_model i_ctl
   (
      .ref_clk(ref_clk),
      .waitrequest(waitrequest),
      .readdata(readdata),
      .address(address),
      .read(read),
      .write(write),
      .writedata(writedata)
   );

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Tick phase is hidden, so wait past one full tick plus the output delay
   task automatic tk();
      repeat (210) @(posedge ref_clk);
   endtask : tk

   task automatic mv(input logic signed [31:0] v);
      @(posedge ref_clk);
      axis_pos <= v;
      tk();
   endtask : mv

   task automatic cmd(input logic c);
      i_ctl.wr(`VCL_REG_CTRL, {30'h00000000, err_en, c});
      tk();
   endtask : cmd

   task automatic cfg(input logic [2:0] m, input logic [31:0] pre, input logic [31:0] post);
      i_ctl.wr(`VCL_REG_MODE, {29'h00000000, m});
      i_ctl.wr(`VCL_REG_OFF_ADDR, pre);
      i_ctl.wr(`VCL_REG_ON_ADDR, post);
   endtask : cfg

   // Pin and status bit must agree
   task automatic cl(input logic e);
      `CHK(clutch_on, e)
      i_ctl.rd(`VCL_REG_STATUS, rv);
      `CHK(rv[0], e)
   endtask : cl

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_reset();
      `CHK(clutch_on, 1'b0)
      `CHK(servo_off_grant, 1'b0)
      i_ctl.rd(`VCL_REG_STATUS, rv);
      `CHK(rv, 32'h00000000)
      i_ctl.rd(5'h14, rv);
      `CHK(rv, 32'h00000000)
   endtask : t_reset

   task automatic t_mode_err();
      for (int m = 0; m < 5; m++)
      begin
         i_ctl.wr(`VCL_REG_MODE, m);
         i_ctl.rd(`VCL_REG_MODE, rv);
         `CHK(rv[2:0], m[2:0])
      end
      i_ctl.wr(`VCL_REG_MODE, 32'h00000003);
      i_ctl.wr(`VCL_REG_MODE, 32'h00000005);
      i_ctl.rd(`VCL_REG_MODE, rv);
      `CHK(rv[2:0], 3'h3)
      i_ctl.rd(`VCL_REG_STATUS, rv);
      `CHK(rv[1], 1'b1)
   endtask : t_mode_err

   task automatic t_oneshot();
      cfg(3'h3, 32'h0000000A, 32'h00000005);
      cmd(1'b1);
      cl(1'b0);
      `CHK(rv[3], 1'b1)
      mv(4);
      cl(1'b0);
      mv(10);
      cl(1'b1);
      cmd(1'b0);
      cl(1'b1);
      mv(14);
      cl(1'b1);
      mv(15);
      cl(1'b0);
      // Negative post travel after a zero pre travel
      cfg(3'h3, 32'h00000000, 32'hFFFFFFFD);
      cmd(1'b1);
      cl(1'b1);
      mv(13);
      cl(1'b1);
      mv(12);
      cl(1'b0);
      // Both travels met inside one tick leave the status alone
      cmd(1'b0);
      cfg(3'h3, 32'h00000002, 32'h00000002);
      cmd(1'b1);
      mv(20);
      cl(1'b0);
   endtask : t_oneshot

   task automatic t_mode4();
      cmd(1'b0);
      cfg(3'h3, 32'h00000000, 32'h00000064);
      cmd(1'b1);
      cl(1'b1);
      i_ctl.wr(`VCL_REG_MODE, 32'h00000004);
      tk();
      cl(1'b1);
      mv(120);
      cl(1'b0);
      cmd(1'b0);
      cmd(1'b1);
      cl(1'b0);
      i_ctl.wr(`VCL_REG_MODE, 32'h00000003);
      tk();
      cl(1'b0);
      cmd(1'b0);
      cmd(1'b1);
      cl(1'b1);
      mv(220);
      cl(1'b0);
   endtask : t_mode4

   task automatic t_error();
      err_en = 1'b1;
      cmd(1'b0);
      cfg(3'h3, 32'h00000000, 32'h000003E8);
      cmd(1'b1);
      cl(1'b1);
      @(posedge ref_clk);
      major_err <= 1'b1;
      tk();
      cl(1'b0);
      `CHK(rv[2], 1'b1)
      @(posedge ref_clk);
      major_err <= 1'b0;
      tk();
      cmd(1'b0);
      cl(1'b0);
      `CHK(rv[2], 1'b0)
      cmd(1'b1);
      cl(1'b1);
      mv(1220);
      cl(1'b0);
      err_en = 1'b0;
   endtask : t_error

   task automatic t_mode2();
      cmd(1'b0);
      cfg(3'h2, 32'h00000050, 32'h00000032);
      mv(0);
      cmd(1'b1);
      mv(60);
      cl(1'b1);
      @(posedge ref_clk);
      servo_off_req <= 1'b1;
      tk();
      `CHK(servo_off_grant, 1'b0)
      cmd(1'b0);
      cl(1'b0);
      `CHK(servo_off_grant, 1'b1)
      // Servo back on before the command returns high
      @(posedge ref_clk);
      servo_off_req <= 1'b0;
      tk();
      cmd(1'b1);
      mv(90);
      cl(1'b0);
      // Downward pass meets the release point first, then engages
      mv(40);
      cl(1'b1);
      // Upward pass meets the engage point first, then releases
      mv(85);
      cl(1'b0);
      mv(40);
      cl(1'b1);
      // Disengaged below both points: engage then release in one tick
      cmd(1'b0);
      cmd(1'b1);
      mv(85);
      cl(1'b0);
   endtask : t_mode2

   // ----------------------------------------------------------------------
   // Run control
   // ----------------------------------------------------------------------
   task automatic complete_run();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run

   // Main sequence; the first tick after reset only primes history
   initial
   begin
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      t_reset();
      tk();
      tk();
      t_mode_err();
      t_oneshot();
      t_mode4();
      t_error();
      t_mode2();
      complete_run();
   end

   // Watchdog sized well above the roughly 50 us the scenarios need
   initial
   begin
      #400us;
      num_errors++;
      $display("watchdog expired");
      complete_run();
   end

endmodule : test_virtual_clutch_oneshot_control
